// ---- include/aecp_pkg.sv ----
`default_nettype none
package aecp_pkg;

    typedef struct packed {
        logic [1:0]  u_sync;
        logic [1:0]  l_sync;
        logic        u_prev;
        logic        l_prev;
        logic [7:0]  ctrl;
        logic [7:0]  ucnt;
        logic [7:0]  lcnt;
        logic        irq_flag;
        logic        irq_en;
        logic        stby_n;
        logic        aw_got;
        logic [7:0]  aw_addr;
        logic        w_got;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
    } aecp_state_t;

endpackage : aecp_pkg
`default_nettype wire

// ---- include/aecp_regs.svh ----
`ifndef AECP_REGS_SVH
`define AECP_REGS_SVH

// register byte offsets
`define AECP_OFF_CTRL    8'h00
`define AECP_OFF_UCNT    8'h04
`define AECP_OFF_LCNT    8'h08
`define AECP_OFF_IRQ     8'h0c
`define AECP_OFF_STBY    8'h10

// event_counter_ctrl_status fields
`define AECP_BIT_OVU     7
`define AECP_BIT_OVL     6
`define AECP_BIT_RSV     5
`define AECP_BIT_SPLIT   4
`define AECP_BIT_CEU     3
`define AECP_BIT_CEL     2
`define AECP_BIT_RELU    1
`define AECP_BIT_RELL    0

// interrupt register fields
`define AECP_BIT_IRQF    0
`define AECP_BIT_IRQE    1

// standby register field
`define AECP_BIT_STBY    0

// reset values and count maximum
`define AECP_CTRL_RST    8'h00
`define AECP_CNT_RST     8'h00
`define AECP_STBY_RST    1'b1
`define AECP_CNT_MAX     8'hff

// bus answers and unmapped register index
`define AECP_RESP_OKAY   2'b00
`define AECP_RESP_SLVERR 2'b10
`define AECP_IDX_NONE    3'h7

`endif

// ---- rtl/aecp_counter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "aecp_regs.svh"

// Functional notes
// [RL1] split select 1: two independent 8-bit counters, no carry between them
// [RL2] split mode: upper counts upper pin edges only, lower counts lower pin only
// [RL3] split mode: upper wraps ff to 00, sets upper overflow flag, keeps counting
// [RL4] split mode: lower wraps ff to 00, sets lower overflow flag, keeps counting
// [RL5] any counter overflow sets the shared interrupt request flag; here a lower overflow in chained mode does not set it
// [RL6] interrupt request reaches the processor only while interrupt enable is 1
// [RL7] low-power modes: counting continues, overflow flags stay untouched
// [RL8] software clears both count enables before reading a counter
// [RL9] clearing a count enable may still let one more increment through
// [RL10] chained mode: software sets upper enable before or with upper release
// [RL11] chained mode: software leaves upper enable alone while counting
// [RL12] split select 0: lower overflow clocks upper, forming one 16-bit counter
// [RL13] count enable 0 blocks events and holds value; 1 lets events increment
// [RL14] release bit 0 holds its counter at zero; 1 allows counting
// [RL15] standby control 0 puts block in module standby; reset value 1
// [RL16] reset clears control and counters; standby halts counters, holds control
// [RL17] event pins pass a two-stage synchroniser before edge detection
module aecp_counter
    import aecp_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input  wire logic              clk,
    input  wire logic              sys_rst,
    input  wire logic              upper_event_pin,
    input  wire logic              lower_event_pin,
    input  wire logic              low_power_mode,
    input  wire logic              ctrl_hold,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   irq_req
);

    if (ADDR_W < 8) begin : g_bad_addr
        $error("aecp_counter: ADDR_W must be at least 8");
    end

    aecp_state_t s_r;
    aecp_state_t s_nxt;

    logic       ev_u;
    logic       ev_l;
    logic       split;
    logic       l_inc;
    logic       l_wrap;
    logic       u_inc;
    logic       u_wrap;
    logic       set_ovu;
    logic       set_ovl;
    logic       set_irq;
    logic       wr_do;
    logic [2:0] wr_idx;
    logic [7:0] wr_data;

    function automatic logic [2:0] reg_index(input logic [7:0] a);
        case (a)
            `AECP_OFF_CTRL: reg_index = 3'h0;
            `AECP_OFF_UCNT: reg_index = 3'h1;
            `AECP_OFF_LCNT: reg_index = 3'h2;
            `AECP_OFF_IRQ:  reg_index = 3'h3;
            `AECP_OFF_STBY: reg_index = 3'h4;
            default:        reg_index = `AECP_IDX_NONE;
        endcase
    endfunction : reg_index

    assign s_axi_awready = ~s_r.aw_got & ~s_r.bvalid;
    assign s_axi_wready  = ~s_r.w_got & ~s_r.bvalid;
    assign s_axi_arready = ~s_r.rvalid;
    assign s_axi_bvalid  = s_r.bvalid;
    assign s_axi_bresp   = s_r.bresp;
    assign s_axi_rvalid  = s_r.rvalid;
    assign s_axi_rdata   = s_r.rdata;
    assign s_axi_rresp   = s_r.rresp;
    assign irq_req       = s_r.irq_flag & s_r.irq_en; // RL6

    always_comb begin
        logic       aw_fire;
        logic       w_fire;
        logic       have_aw;
        logic       have_w;
        logic [7:0] wa;
        logic       ws;
        logic [2:0] ridx;
        logic       locked;
        aw_fire = s_axi_awvalid & s_axi_awready;
        w_fire  = s_axi_wvalid & s_axi_wready;
        have_aw = s_r.aw_got | aw_fire;
        have_w  = s_r.w_got | w_fire;
        wa      = s_r.aw_got ? s_r.aw_addr : s_axi_awaddr[7:0];
        ws      = s_r.w_got ? s_r.w_strb0 : s_axi_wstrb[0];
        ridx    = reg_index(s_axi_araddr[7:0]);
        // module standby and watch/standby block writes to the control register
        locked  = ctrl_hold | ~s_r.stby_n; // RL16
        s_nxt   = s_r;

        // first stage feeds only the second
        s_nxt.u_sync = {s_r.u_sync[0], upper_event_pin}; // RL17
        s_nxt.l_sync = {s_r.l_sync[0], lower_event_pin}; // RL17
        s_nxt.u_prev = s_r.u_sync[1];
        s_nxt.l_prev = s_r.l_sync[1];
        ev_u  = s_r.u_sync[1] & ~s_r.u_prev;
        ev_l  = s_r.l_sync[1] & ~s_r.l_prev;
        split = s_r.ctrl[`AECP_BIT_SPLIT];

        // an edge detected in the same cycle as the write that clears the enable still counts
        l_inc  = s_r.stby_n & ev_l & s_r.ctrl[`AECP_BIT_CEL] & s_r.ctrl[`AECP_BIT_RELL]; // RL13 RL9 RL15
        l_wrap = l_inc & (s_r.lcnt == `AECP_CNT_MAX);
        u_inc  = s_r.stby_n & (split ? ev_u : l_wrap) // RL2 RL12 RL1
                 & s_r.ctrl[`AECP_BIT_CEU] & s_r.ctrl[`AECP_BIT_RELU]; // RL13
        u_wrap = u_inc & (s_r.ucnt == `AECP_CNT_MAX);

        if (!s_r.ctrl[`AECP_BIT_RELL]) begin
            s_nxt.lcnt = `AECP_CNT_RST; // RL14
        end else if (l_inc) begin
            s_nxt.lcnt = 8'(s_r.lcnt + 8'h01); // RL4
        end
        if (!s_r.ctrl[`AECP_BIT_RELU]) begin
            s_nxt.ucnt = `AECP_CNT_RST; // RL14
        end else if (u_inc) begin
            s_nxt.ucnt = 8'(s_r.ucnt + 8'h01); // RL3
        end

        set_ovu = u_wrap & ~low_power_mode; // RL3 RL7
        set_ovl = l_wrap & split & ~low_power_mode; // RL4 RL7
        set_irq = u_wrap | (l_wrap & split); // RL5

        // write channel: address and data in either order
        wr_do   = have_aw & have_w;
        wr_idx  = reg_index(wa);
        wr_data = s_r.w_got ? s_r.w_data : s_axi_wdata[7:0];
        if (wr_do) begin
            s_nxt.aw_got = 1'b0;
            s_nxt.w_got  = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.bresp  = (wr_idx == `AECP_IDX_NONE) ? `AECP_RESP_SLVERR : `AECP_RESP_OKAY;
            if (ws) begin
                unique case (wr_idx)
                    3'h0: begin
                        if (!locked) begin
                            // flags only clear by writing 0
                            s_nxt.ctrl[5:0] = wr_data[5:0];
                            s_nxt.ctrl[`AECP_BIT_OVU] = s_r.ctrl[`AECP_BIT_OVU] & wr_data[`AECP_BIT_OVU];
                            s_nxt.ctrl[`AECP_BIT_OVL] = s_r.ctrl[`AECP_BIT_OVL] & wr_data[`AECP_BIT_OVL];
                        end
                    end
                    3'h3: begin
                        s_nxt.irq_flag = s_r.irq_flag & wr_data[`AECP_BIT_IRQF];
                        s_nxt.irq_en   = wr_data[`AECP_BIT_IRQE];
                    end
                    3'h4: s_nxt.stby_n = wr_data[`AECP_BIT_STBY]; // RL15
                    default: ;
                endcase
            end
        end else begin
            if (aw_fire) begin
                s_nxt.aw_got  = 1'b1;
                s_nxt.aw_addr = s_axi_awaddr[7:0];
            end
            if (w_fire) begin
                s_nxt.w_got   = 1'b1;
                s_nxt.w_data  = s_axi_wdata[7:0];
                s_nxt.w_strb0 = s_axi_wstrb[0];
            end
        end
        if (s_r.bvalid && s_axi_bready) begin
            s_nxt.bvalid = 1'b0;
        end

        // set beats a clear in the same cycle
        if (set_ovu) begin
            s_nxt.ctrl[`AECP_BIT_OVU] = 1'b1; // RL3
        end
        if (set_ovl) begin
            s_nxt.ctrl[`AECP_BIT_OVL] = 1'b1; // RL4
        end
        if (set_irq) begin
            s_nxt.irq_flag = 1'b1; // RL5
        end

        // read channel: counters are not snapshotted, so reads may tear
        if (s_axi_arvalid && s_axi_arready) begin
            s_nxt.rvalid = 1'b1;
            s_nxt.rresp  = (ridx == `AECP_IDX_NONE) ? `AECP_RESP_SLVERR : `AECP_RESP_OKAY;
            unique case (ridx)
                3'h0:    s_nxt.rdata = {24'h000000, s_r.ctrl};
                3'h1:    s_nxt.rdata = {24'h000000, s_r.ucnt};
                3'h2:    s_nxt.rdata = {24'h000000, s_r.lcnt};
                3'h3:    s_nxt.rdata = {30'h0, s_r.irq_en, s_r.irq_flag};
                3'h4:    s_nxt.rdata = {31'h0, s_r.stby_n};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end else if (s_r.rvalid && s_axi_rready) begin
            s_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s_r        <= '0; // RL16
            s_r.stby_n <= `AECP_STBY_RST; // RL15
        end else begin
            s_r <= s_nxt;
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence seq_chain_carry;
        !split && l_wrap && s_r.ctrl[`AECP_BIT_CEU] && s_r.ctrl[`AECP_BIT_RELU] && s_r.stby_n;
    endsequence

    a_split_no_carry: assert property (split && l_wrap && !ev_u |=> $stable(s_r.ucnt)) // RL1
        else $error("upper counter moved on lower wrap in split mode");
    a_upper_source: assert property (split && !ev_u && s_r.ctrl[`AECP_BIT_RELU] |=> $stable(s_r.ucnt)) // RL2
        else $error("upper counter moved without upper pin edge");
    a_upper_wrap: assert property (split && u_wrap && !low_power_mode
                                   |=> s_r.ucnt == 8'h00 && s_r.ctrl[`AECP_BIT_OVU]) // RL3
        else $error("upper wrap did not clear count and set flag");
    a_lower_wrap: assert property (split && l_wrap && !low_power_mode
                                   |=> s_r.lcnt == 8'h00 && s_r.ctrl[`AECP_BIT_OVL]) // RL4
        else $error("lower wrap did not clear count and set flag");
    a_irq_flag_set: assert property (set_irq |=> s_r.irq_flag ##1 s_r.irq_flag || $past(wr_do)) // RL5
        else $error("overflow did not set interrupt flag");
    a_irq_gate: assert property (irq_req |-> s_r.irq_en && s_r.irq_flag) // RL6
        else $error("interrupt request without enable");
    a_lowpower_flags: assert property (low_power_mode && !wr_do
                                       |=> s_r.ctrl[7:6] == $past(s_r.ctrl[7:6])) // RL7
        else $error("overflow flag changed in low-power mode");
    a_chain_carry: assert property (seq_chain_carry |=> s_r.ucnt == 8'($past(s_r.ucnt) + 8'h01)) // RL12
        else $error("16-bit carry not taken by upper counter");
    a_hold_value: assert property (!s_r.ctrl[`AECP_BIT_CEL] && s_r.ctrl[`AECP_BIT_RELL]
                                   |=> $stable(s_r.lcnt)) // RL13
        else $error("lower counter moved while disabled");
    a_release_clear: assert property (!s_r.ctrl[`AECP_BIT_RELL] |=> s_r.lcnt == 8'h00) // RL14
        else $error("lower counter not held at zero");
    a_standby_halt: assert property (!s_r.stby_n && s_r.ctrl[`AECP_BIT_RELU]
                                     |=> $stable(s_r.ucnt) && $stable(s_r.ctrl[5:0])) // RL16 RL15
        else $error("counter or control changed in module standby");

endmodule : aecp_counter

`default_nettype wire

// ---- sim/aecp_event_src.sv ----
`timescale 1ns/1ns
`default_nettype none
module aecp_event_src (
    input  wire logic clk,
    output var logic  upper_event_pin,
    output var logic  lower_event_pin
);
    initial begin
        upper_event_pin = 1'b0;
        lower_event_pin = 1'b0;
    end
    // one cycle low, two cycles high, then one cycle plus gap low, for each pulse
    task automatic pulse(input logic [1:0] sel, input int n, input int gap);
        repeat (n) begin
            @(posedge clk);
            {upper_event_pin, lower_event_pin} <= sel;
            repeat (2) @(posedge clk);
            {upper_event_pin, lower_event_pin} <= 2'b00;
            repeat (1 + gap) @(posedge clk);
        end
    endtask : pulse
endmodule : aecp_event_src
`default_nettype wire

// ---- sim/tb_async_event_counter_pair.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "aecp_regs.svh"
module tb_async_event_counter_pair;
    logic        clk = 1'b0, sys_rst = 1'b1, low_power_mode = 1'b0, ctrl_hold = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_req;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    wire         upper_event_pin, lower_event_pin;
    int          mismatches = 0, checked = 0, cycles = 0;

    aecp_counter aecp_counter_i (.clk, .sys_rst, .upper_event_pin, .lower_event_pin, .low_power_mode,
        .ctrl_hold, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq_req);
    aecp_event_src aecp_event_src_i (.clk, .upper_event_pin, .lower_event_pin);

    always #10 clk = ~clk;

    task automatic summarize();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // whole run is near 4300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            summarize();
        end
    end

    task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        logic aw_ok;
        logic w_ok;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        v = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        rd(a, d, r);
        chk({r, d}, {`AECP_RESP_OKAY, exp});
    endtask : rchk

    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rchk(`AECP_OFF_CTRL, 32'h00);
        rchk(`AECP_OFF_LCNT, 32'h00);
        rchk(`AECP_OFF_STBY, 32'h01);
        chk(irq_req, 1'b0);
        rd(8'h14, d, r);
        chk({r, d}, {`AECP_RESP_SLVERR, 32'h0});
        wr(`AECP_OFF_CTRL, 32'h1f, `AECP_RESP_OKAY);
        aecp_event_src_i.pulse(2'b01, 3, 0);
        aecp_event_src_i.pulse(2'b10, 2, 5);
        rchk(`AECP_OFF_LCNT, 32'h03);
        rchk(`AECP_OFF_UCNT, 32'h02);
        // lower wraps alone; upper must not see a carry
        aecp_event_src_i.pulse(2'b01, 253, 0);
        rchk(`AECP_OFF_LCNT, 32'h00);
        rchk(`AECP_OFF_UCNT, 32'h02);
        rchk(`AECP_OFF_CTRL, 32'h5f);
        rchk(`AECP_OFF_IRQ, 32'h01);
        chk(irq_req, 1'b0);
        wr(`AECP_OFF_IRQ, 32'h03, `AECP_RESP_OKAY);
        chk(irq_req, 1'b1);
        // clear the shared flag so the upper wrap must set it again
        wr(`AECP_OFF_IRQ, 32'h02, `AECP_RESP_OKAY);
        chk(irq_req, 1'b0);
        aecp_event_src_i.pulse(2'b10, 254, 0);
        rchk(`AECP_OFF_UCNT, 32'h00);
        rchk(`AECP_OFF_CTRL, 32'hdf);
        rchk(`AECP_OFF_IRQ, 32'h03);
        chk(irq_req, 1'b1);
        wr(`AECP_OFF_CTRL, 32'h1f, `AECP_RESP_OKAY);
        wr(`AECP_OFF_IRQ, 32'h02, `AECP_RESP_OKAY);
        chk(irq_req, 1'b0);
        @(posedge clk);
        low_power_mode <= 1'b1;
        aecp_event_src_i.pulse(2'b01, 257, 0);
        rchk(`AECP_OFF_LCNT, 32'h01);
        rchk(`AECP_OFF_CTRL, 32'h1f);
        rchk(`AECP_OFF_IRQ, 32'h03);
        @(posedge clk);
        low_power_mode <= 1'b0;
        wr(`AECP_OFF_CTRL, 32'h1b, `AECP_RESP_OKAY);
        aecp_event_src_i.pulse(2'b01, 2, 0);
        rchk(`AECP_OFF_LCNT, 32'h01);
        wr(`AECP_OFF_CTRL, 32'h1a, `AECP_RESP_OKAY);
        rchk(`AECP_OFF_LCNT, 32'h00);
        // chained: the upper pin toggles too and must be ignored
        wr(`AECP_OFF_CTRL, 32'h0f, `AECP_RESP_OKAY);
        // upper enable left alone while the chain counts
        aecp_event_src_i.pulse(2'b11, 256, 0);
        // both enables off before the counters are read
        wr(`AECP_OFF_CTRL, 32'h03, `AECP_RESP_OKAY);
        rchk(`AECP_OFF_LCNT, 32'h00);
        rchk(`AECP_OFF_UCNT, 32'h01);
        rchk(`AECP_OFF_CTRL, 32'h03);
        wr(`AECP_OFF_CTRL, 32'h0f, `AECP_RESP_OKAY);
        wr(`AECP_OFF_STBY, 32'h00, `AECP_RESP_OKAY);
        wr(`AECP_OFF_CTRL, 32'h1f, `AECP_RESP_OKAY);
        aecp_event_src_i.pulse(2'b01, 2, 0);
        rchk(`AECP_OFF_LCNT, 32'h00);
        rchk(`AECP_OFF_CTRL, 32'h0f);
        wr(`AECP_OFF_STBY, 32'h01, `AECP_RESP_OKAY);
        @(posedge clk);
        ctrl_hold <= 1'b1;
        wr(`AECP_OFF_CTRL, 32'h00, `AECP_RESP_OKAY);
        rchk(`AECP_OFF_CTRL, 32'h0f);
        @(posedge clk);
        ctrl_hold <= 1'b0;
        // reserved bit reads back; a write without byte lane 0 changes nothing
        wr(`AECP_OFF_CTRL, 32'h2f, `AECP_RESP_OKAY);
        rchk(`AECP_OFF_CTRL, 32'h2f);
        s_axi_wstrb <= 4'he;
        wr(`AECP_OFF_CTRL, 32'h00, `AECP_RESP_OKAY);
        s_axi_wstrb <= 4'hf;
        rchk(`AECP_OFF_CTRL, 32'h2f);
        wr(8'h14, 32'hff, `AECP_RESP_SLVERR);
        summarize();
    end
endmodule : tb_async_event_counter_pair
`default_nettype wire
